// ### shared/ipd_pkg.sv
package ipd_pkg;

  // descriptor tags
  localparam logic [7:0] FWD_TAG = 8'had;
  localparam logic [7:0] RET_TAG_RST = 8'hae;

  // field widths in bits
  localparam logic [4:0] W_BYTE = 5'h08;
  localparam logic [4:0] W_WORD = 5'h10;
  localparam logic [4:0] W_FLAG = 5'h01;
  localparam logic [4:0] W_CHAN = 5'h04;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_STREAM = 8'h08;
  localparam logic [7:0] REG_RET_TAG = 8'h0c;
  localparam logic [7:0] REG_FWD_PID = 8'h10;

  // register field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CC_BIT = 1;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_FV_BIT = 2;
  localparam int STAT_CNT_LSB = 8;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic CTRL_CC_RST = 1'b0;

  // return label kinds
  localparam logic [1:0] KIND_PID = 2'h1;
  localparam logic [1:0] KIND_ATM = 2'h2;
  localparam logic [1:0] KIND_ROUTE = 2'h3;

  // descriptor kinds seen at the tag
  localparam logic [1:0] DK_OTHER = 2'h0;
  localparam logic [1:0] DK_FWD = 2'h1;
  localparam logic [1:0] DK_RET = 2'h2;

  typedef enum logic [20:0] {
    PH_TAG    = 21'h000001,
    PH_LEN    = 21'h000002,
    PH_ONID   = 21'h000004,
    PH_TSID   = 21'h000008,
    PH_FCNT   = 21'h000010,
    PH_FPID   = 21'h000020,
    PH_RSCNT  = 21'h000040,
    PH_ASSIGN = 21'h000080,
    PH_PFLAG  = 21'h000100,
    PH_PCNT   = 21'h000200,
    PH_PID    = 21'h000400,
    PH_AFLAG  = 21'h000800,
    PH_ACNT   = 21'h001000,
    PH_VPI    = 21'h002000,
    PH_VCI    = 21'h004000,
    PH_RFLAG  = 21'h008000,
    PH_RCNT   = 21'h010000,
    PH_ROUTE  = 21'h020000,
    PH_CHAN   = 21'h040000,
    PH_EMIT   = 21'h080000,
    PH_SKIP   = 21'h100000
  } phase_e;

  typedef struct packed {
    logic first;
    logic [7:0] data;
  } beat_s;

  typedef struct packed {
    logic valid;
    logic assign_lbl;
    logic [1:0] kind;
    logic [3:0] chan;
    logic [23:0] value;
  } label_s;

endpackage

// ### core/path_descriptor_parser.sv
// Overview of operation
// RULE1: tag 0xad selects forward descriptor
// RULE2: length byte bounds the consumed body
// RULE3: forward body: origin and stream labels
// RULE4: low nibble plus one gives pid count
// RULE5: thirteen-bit pid after three reserved bits
// RULE6: incoming pid matched against parsed list
// RULE7: reserved bits ignored entirely
// RULE8: sender randomises reserved bits when encrypted
// RULE9: old parameters kept until replacement arrives
// RULE10: descriptors ignored under connection control
// RULE11: return body: set count plus one
// RULE12: set flag one assigns, zero withdraws
// RULE13: optional pid block with counted entries
// RULE14: assigned return pids delivered downstream
// RULE15: optional atm block of vpi/vci pairs
// RULE16: vpi and vci delivered for cell headers
// RULE17: optional route label block
// RULE18: channel index tags the set labels
// RULE19: set fields decoded in fixed order
// RULE20: msb first; count overrun raises error
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module path_descriptor_parser #(
  parameter int FWD_DEPTH = 8,
  parameter int SET_DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_beat_valid,
  input wire ipd_pkg::beat_s i_beat,
  output logic o_beat_ready,
  input wire logic [12:0] i_rx_pid,
  output logic o_rx_pid_hit,
  output ipd_pkg::label_s o_label,
  output logic o_fwd_update,
  output logic o_parse_err,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp
);
  localparam int FCW = $clog2(FWD_DEPTH + 1);
  localparam int FIW = (FWD_DEPTH > 1) ? $clog2(FWD_DEPTH) : 1;
  localparam int SCW = $clog2(SET_DEPTH + 1);
  localparam int SIW = (SET_DEPTH > 1) ? $clog2(SET_DEPTH) : 1;

  typedef struct packed {
    ipd_pkg::phase_e ph;
    logic [1:0] kind;
    logic [7:0] sh;
    logic [3:0] bits;
    logic [4:0] cnt;
    logic [15:0] acc;
    logic [7:0] rem;
    logic [7:0] left;
    logic [3:0] sets;
    logic asg;
    logic [7:0] vpi;
    logic [3:0] chan;
    logic [SET_DEPTH-1:0][25:0] lbuf;
    logic [SCW-1:0] bcnt;
    logic [SCW-1:0] eidx;
    logic [FWD_DEPTH-1:0][12:0] shadow;
    logic [FCW-1:0] shcnt;
    logic [FWD_DEPTH-1:0][12:0] act;
    logic [FCW-1:0] actcnt;
    logic [15:0] onid;
    logic [31:0] cur;
    logic [31:0] stream;
    logic fv;
    logic ctrl_en;
    logic ctrl_cc;
    logic [7:0] ret_tag;
    logic err;
    logic upd;
    logic hit;
    logic rdy;
    ipd_pkg::label_s lbl;
    logic wpend;
    logic [7:0] waddr;
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
  } st_s;

  localparam st_s ST_RST = '{ph: ipd_pkg::PH_TAG, ctrl_en: ipd_pkg::CTRL_EN_RST, ctrl_cc: ipd_pkg::CTRL_CC_RST,
                             ret_tag: ipd_pkg::RET_TAG_RST, hready: 1'b1, default: '0};

  st_s st_q;
  st_s st_d;
  logic rst_meta_q;
  logic rst_n_q;
  logic [FWD_DEPTH-1:0] match;

  function automatic logic [4:0] fld_width(input ipd_pkg::phase_e ph);
    case (ph)
      ipd_pkg::PH_ONID, ipd_pkg::PH_TSID, ipd_pkg::PH_FPID, ipd_pkg::PH_PID,
      ipd_pkg::PH_VCI, ipd_pkg::PH_ROUTE: fld_width = ipd_pkg::W_WORD;
      ipd_pkg::PH_ASSIGN, ipd_pkg::PH_PFLAG, ipd_pkg::PH_AFLAG,
      ipd_pkg::PH_RFLAG: fld_width = ipd_pkg::W_FLAG;
      ipd_pkg::PH_CHAN: fld_width = ipd_pkg::W_CHAN;
      default: fld_width = ipd_pkg::W_BYTE;
    endcase
  endfunction

  function automatic logic is_body(input ipd_pkg::phase_e ph);
    is_body = !(ph inside {ipd_pkg::PH_TAG, ipd_pkg::PH_LEN, ipd_pkg::PH_EMIT, ipd_pkg::PH_SKIP});
  endfunction

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // RULE6: any active entry matches
  for (genvar g = 0; g < FWD_DEPTH; g++) begin : g_match
    assign match[g] = (FCW'(g) < st_q.actcnt) && (st_q.act[g] == i_rx_pid);
  end

  always_comb begin
    logic take;
    logic errv;
    logic abort;
    logic push;
    logic clr;
    logic [25:0] pushv;
    logic [15:0] v;
    logic [7:0] ra;
    logic [7:0] fi;
    st_d = st_q;
    take = st_q.rdy & i_beat_valid;
    errv = 1'b0;
    abort = 1'b0;
    push = 1'b0;
    clr = 1'b0;
    pushv = '0;
    v = {st_q.acc[14:0], st_q.sh[7]};
    ra = 8'h00;
    fi = 8'h00;
    st_d.upd = 1'b0;
    st_d.lbl.valid = 1'b0;
    st_d.hit = |match;

    if (take) begin
      if (i_beat.first && st_q.ph != ipd_pkg::PH_TAG) begin
        errv = 1'b1;
        st_d.ph = ipd_pkg::PH_TAG;
        st_d.cnt = '0;
        st_d.sh = i_beat.data;
        st_d.bits = ipd_pkg::BYTE_BITS;
      end else if (st_q.ph == ipd_pkg::PH_SKIP) begin
        st_d.rem = st_q.rem - 8'h01;
      end else begin
        st_d.sh = i_beat.data;
        st_d.bits = ipd_pkg::BYTE_BITS;
        // RULE2: body bytes counted off
        if (is_body(st_q.ph)) begin
          st_d.rem = st_q.rem - 8'h01;
        end
      end
    end else if (st_q.bits != 4'h0 && st_q.ph != ipd_pkg::PH_EMIT && st_q.ph != ipd_pkg::PH_SKIP) begin
      // RULE20: msb first shift
      st_d.acc = v;
      st_d.sh = {st_q.sh[6:0], 1'b0};
      st_d.bits = st_q.bits - 4'h1;
      st_d.cnt = st_q.cnt + 5'h01;
      if (st_q.cnt == fld_width(st_q.ph) - 5'h01) begin
        st_d.cnt = '0;
        case (st_q.ph)
          ipd_pkg::PH_TAG: begin
            st_d.ph = ipd_pkg::PH_LEN;
            // RULE1: forward tag compare
            if (v[7:0] == ipd_pkg::FWD_TAG) begin
              st_d.kind = ipd_pkg::DK_FWD;
            end else if (v[7:0] == st_q.ret_tag) begin
              st_d.kind = ipd_pkg::DK_RET;
            end else begin
              st_d.kind = ipd_pkg::DK_OTHER;
            end
          end
          ipd_pkg::PH_LEN: begin
            st_d.rem = v[7:0];
            st_d.shcnt = '0;
            // RULE10: skip under connection control
            if (!st_q.ctrl_en || st_q.ctrl_cc || st_q.kind == ipd_pkg::DK_OTHER) begin
              st_d.ph = ipd_pkg::PH_SKIP;
              st_d.bits = 4'h0;
            end else if (st_q.kind == ipd_pkg::DK_FWD) begin
              st_d.ph = ipd_pkg::PH_ONID;
            end else begin
              st_d.ph = ipd_pkg::PH_RSCNT;
            end
          end
          // RULE3: stream entry labels
          ipd_pkg::PH_ONID: begin
            st_d.onid = v;
            st_d.ph = ipd_pkg::PH_TSID;
          end
          ipd_pkg::PH_TSID: begin
            st_d.cur = {st_q.onid, v};
            st_d.ph = ipd_pkg::PH_FCNT;
          end
          // RULE4: count nibble, reserved dropped
          ipd_pkg::PH_FCNT: begin
            // RULE7: reserved nibble dropped
            st_d.left = {4'h0, v[3:0]};
            st_d.ph = ipd_pkg::PH_FPID;
          end
          // RULE5: store thirteen-bit pid
          ipd_pkg::PH_FPID: begin
            if (st_q.shcnt == FCW'(FWD_DEPTH)) begin
              errv = 1'b1;
            end else begin
              st_d.shadow[st_q.shcnt[FIW-1:0]] = v[12:0];
              st_d.shcnt = st_q.shcnt + 1'b1;
            end
            st_d.left = st_q.left - 8'h01;
            st_d.ph = (st_q.left == 8'h00) ? ipd_pkg::PH_ONID : ipd_pkg::PH_FPID;
          end
          // RULE11: set count nibble
          ipd_pkg::PH_RSCNT: begin
            st_d.sets = v[3:0];
            st_d.ph = ipd_pkg::PH_ASSIGN;
          end
          // RULE12: assign or withdraw
          ipd_pkg::PH_ASSIGN: begin
            st_d.asg = v[0];
            st_d.bcnt = '0;
            st_d.ph = ipd_pkg::PH_PFLAG;
          end
          // RULE19: fixed decode order
          ipd_pkg::PH_PFLAG: st_d.ph = v[0] ? ipd_pkg::PH_PCNT : ipd_pkg::PH_AFLAG;
          ipd_pkg::PH_AFLAG: st_d.ph = v[0] ? ipd_pkg::PH_ACNT : ipd_pkg::PH_RFLAG;
          ipd_pkg::PH_RFLAG: st_d.ph = v[0] ? ipd_pkg::PH_RCNT : ipd_pkg::PH_CHAN;
          ipd_pkg::PH_PCNT: begin
            st_d.left = v[7:0];
            st_d.ph = ipd_pkg::PH_PID;
          end
          ipd_pkg::PH_ACNT: begin
            st_d.left = v[7:0];
            st_d.ph = ipd_pkg::PH_VPI;
          end
          ipd_pkg::PH_RCNT: begin
            st_d.left = v[7:0];
            st_d.ph = ipd_pkg::PH_ROUTE;
          end
          // RULE13: pid block entries
          ipd_pkg::PH_PID: begin
            push = 1'b1;
            pushv = {ipd_pkg::KIND_PID, 11'h000, v[12:0]};
            st_d.left = st_q.left - 8'h01;
            st_d.ph = (st_q.left == 8'h00) ? ipd_pkg::PH_AFLAG : ipd_pkg::PH_PID;
          end
          // RULE15: vpi then vci pairs
          ipd_pkg::PH_VPI: begin
            st_d.vpi = v[7:0];
            st_d.ph = ipd_pkg::PH_VCI;
          end
          ipd_pkg::PH_VCI: begin
            push = 1'b1;
            // RULE16: vpi and vci packed
            pushv = {ipd_pkg::KIND_ATM, st_q.vpi, v};
            st_d.left = st_q.left - 8'h01;
            st_d.ph = (st_q.left == 8'h00) ? ipd_pkg::PH_RFLAG : ipd_pkg::PH_VPI;
          end
          // RULE17: route label entries
          ipd_pkg::PH_ROUTE: begin
            push = 1'b1;
            pushv = {ipd_pkg::KIND_ROUTE, 8'h00, v};
            st_d.left = st_q.left - 8'h01;
            st_d.ph = (st_q.left == 8'h00) ? ipd_pkg::PH_CHAN : ipd_pkg::PH_ROUTE;
          end
          ipd_pkg::PH_CHAN: begin
            st_d.chan = v[3:0];
            st_d.eidx = '0;
            st_d.ph = ipd_pkg::PH_EMIT;
          end
          default: abort = 1'b1;
        endcase
      end
    end else if (is_body(st_q.ph) && st_q.bits == 4'h0 && st_q.rem == 8'h00) begin
      // RULE9: commit only a complete list
      if (st_q.ph == ipd_pkg::PH_ONID && st_q.cnt == 5'h00) begin
        st_d.act = st_q.shadow;
        st_d.actcnt = st_q.shcnt;
        st_d.stream = st_q.cur;
        st_d.fv = 1'b1;
        st_d.upd = 1'b1;
        st_d.ph = ipd_pkg::PH_TAG;
      end else begin
        // RULE20: count overran length
        errv = 1'b1;
      end
    end else if (st_q.ph == ipd_pkg::PH_EMIT) begin
      if (st_q.eidx < st_q.bcnt) begin
        // RULE18: channel index on each label
        st_d.lbl = '{1'b1, st_q.asg, st_q.lbuf[st_q.eidx[SIW-1:0]][25:24], st_q.chan,
                     st_q.lbuf[st_q.eidx[SIW-1:0]][23:0]};
        st_d.eidx = st_q.eidx + 1'b1;
      end else if (st_q.sets == 4'h0) begin
        st_d.ph = ipd_pkg::PH_SKIP;
        st_d.bits = 4'h0;
      end else begin
        st_d.sets = st_q.sets - 4'h1;
        st_d.ph = ipd_pkg::PH_ASSIGN;
      end
    end else if (st_q.ph == ipd_pkg::PH_SKIP && st_q.rem == 8'h00) begin
      st_d.ph = ipd_pkg::PH_TAG;
    end

    // RULE14: labels buffered per set
    if (push) begin
      if (st_q.bcnt == SCW'(SET_DEPTH)) begin
        errv = 1'b1;
      end else begin
        st_d.lbuf[st_q.bcnt[SIW-1:0]] = pushv;
        st_d.bcnt = st_q.bcnt + 1'b1;
      end
    end
    if ((errv && !(take && i_beat.first)) || abort) begin
      st_d.ph = ipd_pkg::PH_SKIP;
      st_d.bits = 4'h0;
      st_d.cnt = '0;
    end

    // bus data phase write
    if (st_q.wpend) begin
      case (st_q.waddr)
        ipd_pkg::REG_CTRL: begin
          st_d.ctrl_en = i_hwdata[ipd_pkg::CTRL_EN_BIT];
          st_d.ctrl_cc = i_hwdata[ipd_pkg::CTRL_CC_BIT];
        end
        ipd_pkg::REG_STATUS: clr = i_hwdata[ipd_pkg::STAT_ERR_BIT];
        ipd_pkg::REG_RET_TAG: st_d.ret_tag = i_hwdata[7:0];
        default: clr = 1'b0;
      endcase
    end
    st_d.err = (st_q.err & ~clr) | errv | abort;

    // bus address phase
    st_d.wpend = 1'b0;
    if (i_hsel && i_hready && i_htrans[1]) begin
      ra = i_haddr[7:0];
      if (i_hwrite) begin
        st_d.wpend = 1'b1;
        st_d.waddr = ra;
      end else begin
        st_d.hrdata = 32'h0000_0000;
        fi = (ra - ipd_pkg::REG_FWD_PID) >> 2;
        case (ra)
          ipd_pkg::REG_CTRL: begin
            st_d.hrdata[ipd_pkg::CTRL_EN_BIT] = st_q.ctrl_en;
            st_d.hrdata[ipd_pkg::CTRL_CC_BIT] = st_q.ctrl_cc;
          end
          ipd_pkg::REG_STATUS: begin
            st_d.hrdata[ipd_pkg::STAT_ERR_BIT] = st_q.err;
            st_d.hrdata[ipd_pkg::STAT_BUSY_BIT] = (st_q.ph != ipd_pkg::PH_TAG);
            st_d.hrdata[ipd_pkg::STAT_FV_BIT] = st_q.fv;
            st_d.hrdata[ipd_pkg::STAT_CNT_LSB +: FCW] = st_q.actcnt;
          end
          ipd_pkg::REG_STREAM: st_d.hrdata = st_q.stream;
          ipd_pkg::REG_RET_TAG: st_d.hrdata[7:0] = st_q.ret_tag;
          default: begin
            if (ra >= ipd_pkg::REG_FWD_PID && ra[1:0] == 2'h0 && fi < 8'(FWD_DEPTH)) begin
              st_d.hrdata[12:0] = st_q.act[fi[FIW-1:0]];
            end
          end
        endcase
      end
    end

    // a take always costs ready for one cycle, skipped bytes too
    st_d.rdy = (st_d.bits == 4'h0) && !take &&
               (st_d.ph inside {ipd_pkg::PH_TAG, ipd_pkg::PH_LEN} ||
                (st_d.ph != ipd_pkg::PH_EMIT && st_d.rem != 8'h00));
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_beat_ready = st_q.rdy;
  assign o_rx_pid_hit = st_q.hit;
  assign o_label = st_q.lbl;
  assign o_fwd_update = st_q.upd;
  assign o_parse_err = st_q.err;
  assign o_hreadyout = st_q.hready;
  assign o_hrdata = st_q.hrdata;
  assign o_hresp = st_q.hresp;
endmodule
`default_nettype wire

// ### bench/ipd_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ipd_checker #(
  parameter int FWD_DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_beat_valid,
  input wire logic o_beat_ready,
  input wire logic o_rx_pid_hit,
  input wire ipd_pkg::label_s o_label,
  input wire logic o_fwd_update,
  input wire logic o_parse_err,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hresp
);
  logic st_wr_q, seen_upd_q;
  wire logic rd_ap = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
  wire logic clr = st_wr_q && i_hwdata[ipd_pkg::STAT_ERR_BIT];
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st_wr_q <= 1'b0;
      seen_upd_q <= 1'b0;
    end else begin
      st_wr_q <= i_hsel && i_hready && i_htrans[1] && i_hwrite && i_haddr == 32'(ipd_pkg::REG_STATUS);
      if (o_fwd_update) seen_upd_q <= 1'b1;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  sequence s_take;
    i_beat_valid && o_beat_ready;
  endsequence
  sequence s_rd_unmapped;
    rd_ap && i_haddr >= 32'h10 + 32'(4 * FWD_DEPTH);
  endsequence
  a_take_drops_ready: assert property (s_take |=> !o_beat_ready) else $error("ready held after take");
  a_bus_no_wait: assert property (o_hreadyout && !o_hresp) else $error("wait state or error response");
  a_update_one_pulse: assert property (o_fwd_update |=> !o_fwd_update) else $error("update pulse too long");
  a_err_clear_cause: assert property ($fell(o_parse_err) |-> $past(clr)) else $error("error flag lost");
  a_rdata_holds: assert property (!$past(rd_ap) |-> $stable(o_hrdata)) else $error("read data moved");
  a_unmapped_zero: assert property (s_rd_unmapped |=> o_hrdata == 32'h0) else $error("unmapped read nonzero");
  a_label_no_take: assert property (o_label.valid |-> !o_beat_ready) else $error("byte taken during emit");
  a_hit_needs_list: assert property (o_rx_pid_hit |-> seen_upd_q || o_fwd_update) else $error("hit without list");
endmodule
`default_nettype wire

// ### bench/ncc_sender.sv
`timescale 1ns/1ps
`default_nettype none
module ncc_sender (
  input wire logic i_clk,
  input wire logic i_ready,
  input wire logic i_slow,
  output logic o_valid,
  output ipd_pkg::beat_s o_beat
);
  ipd_pkg::beat_s q[$];
  logic gap;
  initial begin
    o_valid = 1'b0;
    o_beat = '0;
    gap = 1'b0;
  end
  // bytes sent whole and in order
  always @(posedge i_clk) begin
    if (o_valid && i_ready) begin
      o_valid <= 1'b0;
      o_beat <= ipd_pkg::beat_s'(~o_beat);
      gap <= i_slow;
    end else if (!o_valid && q.size() != 0 && !gap) begin
      o_valid <= 1'b1;
      o_beat <= q.pop_front();
    end else begin
      gap <= 1'b0;
      if (!o_valid) o_beat <= ipd_pkg::beat_s'(~o_beat);
    end
  end
endmodule
`default_nettype wire

// ### bench/interaction_path_descriptor_parser_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module interaction_path_descriptor_parser_tb_top;
  logic i_clk_sys, i_resetn, i_beat_valid, o_beat_ready, o_rx_pid_hit, o_fwd_update, o_parse_err;
  logic i_hsel, i_hwrite, o_hreadyout, o_hresp, slow;
  ipd_pkg::beat_s i_beat;
  ipd_pkg::label_s o_label;
  logic [12:0] i_rx_pid;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd, strm, lstrm;
  logic [1:0] i_htrans;
  logic [2:0] i_hsize;
  int n_mismatch, check_count, seed, n_upd;
  logic [12:0] pids[$], act[$];
  ipd_pkg::label_s exp_q[$], got_q[$];
  bit bq[$];
  path_descriptor_parser path_descriptor_parser_i (.i_clk_sys, .i_resetn, .i_beat_valid, .i_beat, .o_beat_ready,
    .i_rx_pid, .o_rx_pid_hit, .o_label, .o_fwd_update, .o_parse_err, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hsize, .i_hwdata, .i_hready(o_hreadyout), .o_hreadyout, .o_hrdata, .o_hresp);
  ncc_sender ncc_sender_i (.i_clk(i_clk_sys), .i_ready(o_beat_ready), .i_slow(slow), .o_valid(i_beat_valid),
    .o_beat(i_beat));
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    if (o_fwd_update === 1'b1) n_upd++;
    if (o_label.valid === 1'b1) got_q.push_back(o_label);
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic endt(input string n);
    $display("test %s done", n);
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge i_clk_sys);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= a;
    i_hwrite <= w;
    do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
  endtask
  task automatic chk_rd(input string n, input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    `CHK(n, e, rd)
  endtask
  task automatic hit(input logic [12:0] p, input logic e);
    @(posedge i_clk_sys);
    i_rx_pid <= p;
    @(posedge i_clk_sys);
    #1 `CHK("pid_hit", e, o_rx_pid_hit)
  endtask
  task automatic put(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) bq.push_back(v[i]);
  endtask
  // msb-first bit stream cut into bytes behind tag and length
  task automatic send(input logic [7:0] tag, input int cut);
    int nb;
    logic [7:0] b;
    while (bq.size() % 8 != 0) bq.push_back(1'b0);
    nb = bq.size() / 8 - cut;
    ncc_sender_i.q.push_back({1'b1, tag});
    ncc_sender_i.q.push_back({1'b0, 8'(nb)});
    for (int i = 0; i < nb; i++) begin
      for (int j = 0; j < 8; j++) b = {b[6:0], bq[8 * i + j]};
      ncc_sender_i.q.push_back({1'b0, b});
    end
    bq = {};
    for (int k = 0; k < 3000 && !(ncc_sender_i.q.size() == 0 && i_beat_valid === 1'b0 && o_beat_ready === 1'b1); k++)
      @(posedge i_clk_sys);
    repeat (3) @(posedge i_clk_sys);
  endtask
  task automatic fwd(input int ns, input int c7, input int cut);
    logic [3:0] c;
    logic [12:0] p;
    pids = {};
    for (int s = 0; s < ns; s++) begin
      strm = $random(seed);
      put(strm[31:16], 16);
      put(strm[15:0], 16);
      c = (c7 != 0) ? 4'h7 : 4'($random(seed) & 1);
      put(16'($random(seed)), 4);
      put(16'(c), 4);
      for (int k = 0; k <= c; k++) begin
        p = 13'($random(seed));
        pids.push_back(p);
        put(16'($random(seed)), 3);
        put(16'(p), 13);
      end
    end
    send(ipd_pkg::FWD_TAG, cut);
  endtask
  task automatic chk_fwd();
    logic [12:0] m;
    chk_rd("status", 32'h4, (32'(act.size()) << 8) | 32'h4);
    chk_rd("stream", 32'h8, lstrm);
    foreach (act[i]) begin
      chk_rd("fwd_pid", 32'h10 + 32'(4 * i), 32'(act[i]));
      hit(act[i], 1'b1);
    end
    do m = 13'($random(seed)); while (m inside {act});
    hit(m, 1'b0);
  endtask
  task automatic ret(input int nsets);
    logic [3:0] ch;
    logic a;
    logic [2:0] f;
    logic [7:0] c;
    logic [23:0] v;
    exp_q = {};
    got_q = {};
    put(16'($random(seed)), 4);
    put(16'(nsets - 1), 4);
    for (int s = 0; s < nsets; s++) begin
      a = 1'($random(seed));
      f = 3'($random(seed));
      ch = 4'($random(seed));
      put(16'(a), 1);
      for (int k = 1; k <= 3; k++) begin
        put(16'(f[k - 1]), 1);
        if (f[k - 1]) begin
          c = 8'($random(seed) & 1);
          put(16'(c), 8);
          for (int j = 0; j <= c; j++) begin
            v = 24'($random(seed)) & (k == 1 ? 24'h1fff : k == 3 ? 24'hffff : 24'hffffff);
            if (k == 1) put(16'($random(seed)), 3);
            if (k == 2) put(16'(v[23:16]), 8);
            put(v[15:0], k == 1 ? 13 : 16);
            exp_q.push_back(ipd_pkg::label_s'{1'b1, a, 2'(k), ch, v});
          end
        end
      end
      put(16'(ch), 4);
    end
    send(8'h9c, 0);
    `CHK("label_count", exp_q.size(), got_q.size())
    foreach (exp_q[i]) if (i < got_q.size()) `CHK("label", exp_q[i], got_q[i])
  endtask
  initial begin
    seed = 32'hd00a;
    i_resetn = 1'b0;
    i_hsel = 1'b0;
    i_haddr = 32'h0;
    i_htrans = 2'h0;
    i_hwrite = 1'b0;
    i_hsize = 3'h2;
    i_hwdata = 32'h0;
    i_rx_pid = 13'h0;
    slow = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    n_upd = 0;
    repeat (5) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    chk_rd("ctrl", 32'h0, 32'h1);
    chk_rd("status", 32'h4, 32'h0);
    chk_rd("ret_tag", 32'hc, 32'hae);
    chk_rd("unmapped", 32'h40, 32'h0);
    ahb(1'b1, 32'hc, 32'h9c);
    chk_rd("ret_tag", 32'hc, 32'h9c);
    endt("registers");
    for (int t = 0; t < 4; t++) begin
      slow <= t[0];
      fwd(t == 0 ? 1 : 2, t == 0, 0);
      act = pids;
      lstrm = strm;
      `CHK("updates", t + 1, n_upd)
      chk_fwd();
    end
    endt("forward");
    ret(1);
    ret(12);
    ret(2 + int'($random(seed) & 3));
    chk_fwd();
    endt("return");
    ahb(1'b1, 32'h0, 32'h3);
    chk_rd("ctrl", 32'h0, 32'h3);
    fwd(2, 0, 0);
    ahb(1'b1, 32'h0, 32'h0);
    fwd(1, 0, 0);
    ahb(1'b1, 32'h0, 32'h1);
    put(16'($random(seed)), 16);
    send(8'h5a, 0);
    `CHK("updates", 4, n_upd)
    chk_fwd();
    endt("ignored");
    fwd(1, 1, 2);
    `CHK("parse_err", 1'b1, o_parse_err)
    chk_rd("status", 32'h4, (32'(act.size()) << 8) | 32'h5);
    ahb(1'b1, 32'h4, 32'h1);
    `CHK("updates", 4, n_upd)
    chk_fwd();
    endt("overrun");
    report_and_stop();
  end
  initial begin
    repeat (50000) @(posedge i_clk_sys);
    n_mismatch++;
    report_and_stop();
  end
endmodule
bind path_descriptor_parser ipd_checker #(.FWD_DEPTH(FWD_DEPTH)) ipd_checker_i (.i_clk_sys, .i_resetn, .i_beat_valid,
  .o_beat_ready, .o_rx_pid_hit, .o_label, .o_fwd_update, .o_parse_err, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
  .i_hwdata, .i_hready, .o_hreadyout, .o_hrdata, .o_hresp);
`default_nettype wire
